// [isamsw_ctrl.sv]
/*
  instruction-set mode bit control: mode tracking for jumps, exception entry and return,
  offset scaling, strap capture, per-context exception select, apb registers and interrupt.
  assumes the pipeline gives at most one of jump, exception and return per cycle (exception
  wins if several arrive), and that straps are stable across reset release.
*/
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module isamsw_ctrl #(
  parameter bit COP_RSVD = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] strap_cap,
  input wire logic strap_exc_sel,
  input wire logic strap_dbg_sel,
  input wire isamsw_pkg::isamsw_req_t core_req,
  output isamsw_pkg::isamsw_rsp_t core_rsp,
  output logic irq
);
  import isamsw_pkg::*;

  logic strap_done_r;
  logic [1:0] cap_r;
  logic [CTX_N-1:0] exc_sel_r;
  logic dbg_sel_r;
  logic [CTX_W-1:0] ctx_r;
  logic [EV_N-1:0] sts_r;
  logic [EV_N-1:0] sts_nxt;
  logic [EV_N-1:0] msk_r;
  logic [EV_N-1:0] ev;
  logic mode_r;
  logic mode_q_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  isamsw_rsp_t rsp_r;
  logic dual;
  logic setup;
  logic wr_en;
  logic entry_mode;

  // offsets become word or halfword displacements depending on mode
  function automatic logic [OFS_W-1:0] scale_offset(input logic [OFS_W-1:0] ofs,
                                                     input logic mode);
    if (mode == MODE_WORD)
    begin
      scale_offset = {ofs[OFS_W-3:0], 2'b00};
    end
    else
    begin
      scale_offset = {ofs[OFS_W-2:0], 1'b0};
    end
  endfunction

  // return address with the mode folded into its lowest bit
  function automatic logic [XLEN-1:0] with_mode(input logic [XLEN-1:0] a, input logic m);
    with_mode = {a[XLEN-1:1], m};
  endfunction

  // program counter value with the mode bit stripped off
  function automatic logic [XLEN-1:0] strip_mode(input logic [XLEN-1:0] a);
    strip_mode = {a[XLEN-1:1], 1'b0};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_FIRST_CFG) || (a == OFS_THIRD_CFG) || (a == OFS_DBG_CTL) ||
             (a == OFS_CTX_SEL) || (a == OFS_IRQ_STS) || (a == OFS_IRQ_MSK);
  endfunction

  // write data honouring byte lane 0 and lane 2, the only lanes holding writable bits
  function automatic logic lane_bit(input logic [31:0] d, input logic [3:0] s, input int b);
    lane_bit = s[b/8] & d[b];
  endfunction

  assign dual = cap_r[CAP_DUAL_BIT];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_r;

  // entry mode: debug uses its own select, base-relative vectors the context select
  always_comb
  begin
    entry_mode = cap_r[0];
    unique case (core_req.exc_kind)
      EK_DEBUG:
      begin
        entry_mode = dbg_sel_r;
      end
      EK_GENERAL, EK_ERROR:
      begin
        if (core_req.exc_base_rel)
        begin
          entry_mode = exc_sel_r[core_req.exc_ctx];
        end
      end
      default:
      begin
        entry_mode = cap_r[0];
      end
    endcase
  end

  // straps are caught on the first edge after release, never inside the reset itself
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_done_r <= 1'b0;
      cap_r <= CAP_WORD_ONLY;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      cap_r <= strap_cap;
    end
  end

  // per-context exception select, debug select and context pointer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exc_sel_r <= '0;
      dbg_sel_r <= 1'b0;
      ctx_r <= '0;
    end
    else if (!strap_done_r)
    begin
      exc_sel_r <= {CTX_N{strap_exc_sel}};
      dbg_sel_r <= strap_dbg_sel;
    end
    else if (wr_en)
    begin
      if (paddr == OFS_THIRD_CFG)
      begin
        exc_sel_r[ctx_r] <= lane_bit(pwdata, pstrb, EXC_SEL_BIT);
      end
      if (paddr == OFS_DBG_CTL)
      begin
        dbg_sel_r <= lane_bit(pwdata, pstrb, DBG_SEL_BIT);
      end
      if (paddr == OFS_CTX_SEL && pstrb[0])
      begin
        ctx_r <= pwdata[CTX_W-1:0];
      end
    end
  end

  // apb slave: data latched in setup, pready rises for exactly one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped(paddr);
      if (setup && !pwrite)
      begin
        prdata_r <= 32'h0000_0000;
        unique case (paddr)
          OFS_FIRST_CFG:
          begin
            prdata_r <= 32'h0000_0000;
          end
          OFS_THIRD_CFG:
          begin
            // mode itself is never mapped here, software sees it only via saved pc and link value
            prdata_r[CAP_LSB+1:CAP_LSB] <= cap_r;
            prdata_r[EXC_SEL_BIT] <= exc_sel_r[ctx_r];
          end
          OFS_DBG_CTL:
          begin
            prdata_r[DBG_SEL_BIT] <= dbg_sel_r;
          end
          OFS_CTX_SEL:
          begin
            prdata_r[CTX_W-1:0] <= ctx_r;
          end
          OFS_IRQ_STS:
          begin
            prdata_r[EV_N-1:0] <= sts_r;
          end
          OFS_IRQ_MSK:
          begin
            prdata_r[EV_N-1:0] <= msk_r;
          end
          default:
          begin
            prdata_r <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // mode bit: strapped at capture, then moved by entries, returns and jumps; a single
  // device keeps its strapped value, so it has no switching path at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= MODE_WORD;
    end
    else if (!strap_done_r)
    begin
      // reset mode from capability: codes 0 and 2 word, 1 and 3 compact
      mode_r <= strap_cap[0];
    end
    else if (dual)
    begin
      if (core_req.exc_valid)
      begin
        mode_r <= entry_mode;
      end
      else if (core_req.eret_valid)
      begin
        mode_r <= core_req.eret_addr[0];
      end
      else if (core_req.jump_valid)
      begin
        mode_r <= core_req.jump_src[0];
      end
    end
  end

  // core side: one response per request, all fields registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsp_r <= '0;
    end
    else if (strap_done_r)
    begin
      rsp_r.target_valid <= 1'b0;
      rsp_r.link_valid <= 1'b0;
      rsp_r.save_valid <= 1'b0;
      rsp_r.addr_exc <= 1'b0;
      rsp_r.rsvd_exc <= 1'b0;
      rsp_r.cu_exc <= 1'b0;
      rsp_r.offset_scaled <= scale_offset(core_req.offset, mode_r);
      if (core_req.exc_valid)
      begin
        rsp_r.save_valid <= 1'b1;
        rsp_r.save_value <= with_mode(core_req.exc_pc, mode_r);
      end
      else if (core_req.eret_valid)
      begin
        rsp_r.target_valid <= 1'b1;
        rsp_r.target_pc <= strip_mode(core_req.eret_addr);
      end
      else if (core_req.jump_valid)
      begin
        rsp_r.target_valid <= 1'b1;
        rsp_r.target_pc <= strip_mode(core_req.jump_src);
        if (!dual && core_req.jump_src[0] != mode_r)
        begin
          rsp_r.addr_exc <= 1'b1;
        end
        if (core_req.jump_link)
        begin
          rsp_r.link_valid <= 1'b1;
          // pre-jump mode; on a single device this is the fixed value
          rsp_r.link_value <= with_mode(core_req.link_pc, mode_r);
        end
      end
      if (core_req.cop_valid && !core_req.exc_valid)
      begin
        // compact mode may report reserved opcode; word mode always unusable
        rsp_r.rsvd_exc <= (mode_r == MODE_COMPACT) && COP_RSVD;
        rsp_r.cu_exc <= (mode_r == MODE_WORD) || !COP_RSVD;
      end
    end
  end

  // delayed mode copy for the switch event; it takes the strapped mode at capture so
  // that a compact reset mode is not mistaken for a switch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q_r <= MODE_WORD;
    end
    else if (!strap_done_r)
    begin
      mode_q_r <= strap_cap[0];
    end
    else
    begin
      mode_q_r <= mode_r;
    end
  end

  // events come from the registered response, so they lag the core pulse by one cycle
  always_comb
  begin
    ev = '0;
    ev[EV_SWITCH] = strap_done_r && (mode_q_r != mode_r);
    ev[EV_ADDR] = rsp_r.addr_exc;
    ev[EV_EXC] = rsp_r.save_valid;
    ev[EV_ERET] = rsp_r.target_valid && !rsp_r.link_valid && (mode_q_r != mode_r);
    sts_nxt = sts_r;
    if (wr_en && paddr == OFS_IRQ_STS && pstrb[0])
    begin
      sts_nxt = sts_r & ~pwdata[EV_N-1:0];
    end
    sts_nxt = sts_nxt | ev; // a set in the clearing cycle survives
  end

  // sticky status, write one to clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sts_r <= '0;
    end
    else
    begin
      sts_r <= sts_nxt;
    end
  end

  // interrupt mask, every source masked out of reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msk_r <= MSK_RESET;
    end
    else if (wr_en && paddr == OFS_IRQ_MSK && pstrb[0])
    begin
      msk_r <= pwdata[EV_N-1:0];
    end
  end

  // level interrupt from the next status, so it rises on the edge that sets the bit;
  // the old mask is used, so a mask write shows one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= |(sts_nxt & msk_r);
    end
  end

  // outputs straight from flip-flops
  always_comb
  begin
    core_rsp = rsp_r;
    core_rsp.mode = mode_r;
  end
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// [isamsw_pkg.sv]
/*
  constants, field layouts and carrier types of the instruction-set mode switch block.
  assumes an apb master on pclk and a core pipeline that gives one-cycle request pulses.
*/
package isamsw_pkg;
  localparam int XLEN = 64;
  localparam int CTX_N = 2;
  localparam int CTX_W = 1;
  localparam int OFS_W = 32;
  // apb byte offsets
  localparam logic [7:0] OFS_FIRST_CFG = 8'h00;
  localparam logic [7:0] OFS_THIRD_CFG = 8'h04;
  localparam logic [7:0] OFS_DBG_CTL = 8'h08;
  localparam logic [7:0] OFS_CTX_SEL = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h14;
  // field positions
  localparam int CAP_LSB = 14;
  localparam int EXC_SEL_BIT = 16;
  localparam int LEGACY_CAP_BIT = 2;
  localparam int DBG_SEL_BIT = 0;
  // capability codes: bit 1 dual, bit 0 reset mode
  localparam logic [1:0] CAP_WORD_ONLY = 2'h0;
  localparam logic [1:0] CAP_COMPACT_ONLY = 2'h1;
  localparam logic [1:0] CAP_DUAL_WORD = 2'h2;
  localparam logic [1:0] CAP_DUAL_COMPACT = 2'h3;
  localparam int CAP_DUAL_BIT = 1;
  // mode values
  localparam logic MODE_WORD = 1'b0;
  localparam logic MODE_COMPACT = 1'b1;
  // interrupt events
  localparam int EV_SWITCH = 0;
  localparam int EV_ADDR = 1;
  localparam int EV_EXC = 2;
  localparam int EV_ERET = 3;
  localparam int EV_N = 4;
  localparam logic [EV_N-1:0] MSK_RESET = 4'h0;

  typedef enum logic [1:0] {EK_GENERAL, EK_DEBUG, EK_ERROR} isamsw_kind_t;

  typedef struct packed {
    logic jump_valid;
    logic jump_link;
    logic [XLEN-1:0] jump_src;
    logic [XLEN-1:0] link_pc;
    logic exc_valid;
    isamsw_kind_t exc_kind;
    logic exc_base_rel;
    logic [CTX_W-1:0] exc_ctx;
    logic [XLEN-1:0] exc_pc;
    logic eret_valid;
    logic [XLEN-1:0] eret_addr;
    logic [OFS_W-1:0] offset;
    logic cop_valid;
  } isamsw_req_t;

  typedef struct packed {
    logic mode;
    logic target_valid;
    logic [XLEN-1:0] target_pc;
    logic link_valid;
    logic [XLEN-1:0] link_value;
    logic save_valid;
    logic [XLEN-1:0] save_value;
    logic addr_exc;
    logic rsvd_exc;
    logic cu_exc;
    logic [OFS_W-1:0] offset_scaled;
  } isamsw_rsp_t;
endpackage

// [isamsw_ctrl_monitor.sv]
/*
  port checker for the mode switch control block.
  assumes pclk and an async active-low presetn, bound to the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module isamsw_ctrl_monitor #(
  parameter bit COP_RSVD = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [1:0] strap_cap,
  input wire isamsw_pkg::isamsw_req_t core_req,
  input wire isamsw_pkg::isamsw_rsp_t core_rsp
);
  import isamsw_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic live_r;
  wire logic dual = strap_cap[CAP_DUAL_BIT];
  wire logic cr = COP_RSVD;
  // requests at the strap capture edge are ignored, so wait one edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      live_r <= 1'b0;
    else
      live_r <= 1'b1;
  // a jump that no exception or return overrides
  sequence jmp_s;
    live_r && core_req.jump_valid && !core_req.exc_valid && !core_req.eret_valid;
  endsequence
  strap_mode_a: assert property (!live_r |=> core_rsp.mode == strap_cap[0])
    else $error("reset mode wrong");
  jump_target_a: assert property (jmp_s |=> core_rsp.target_valid &&
    core_rsp.target_pc == {$past(core_req.jump_src[XLEN-1:1]), 1'b0}) else $error("bad target");
  jump_mode_a: assert property (jmp_s ##0 dual |=>
    core_rsp.mode == $past(core_req.jump_src[0])) else $error("jump mode wrong");
  link_bit_a: assert property (jmp_s ##0 core_req.jump_link |=> core_rsp.link_valid &&
    core_rsp.link_value[0] == $past(core_rsp.mode)) else $error("bad link bit");
  save_bit_a: assert property (live_r && core_req.exc_valid |=> core_rsp.save_valid &&
    core_rsp.save_value[0] == $past(core_rsp.mode)) else $error("bad saved bit");
  eret_mode_a: assert property (live_r && core_req.eret_valid && !core_req.exc_valid
    && dual |=> core_rsp.mode == $past(core_req.eret_addr[0])) else $error("return mode wrong");
  fixed_mode_a: assert property (live_r && !dual |-> core_rsp.mode == strap_cap[0])
    else $error("fixed mode moved");
  addr_fault_a: assert property (jmp_s ##0 !dual &&
    core_req.jump_src[0] != core_rsp.mode |=> core_rsp.addr_exc) else $error("no address fault");
  offset_scale_a: assert property (live_r |=> core_rsp.offset_scaled ==
    ($past(core_rsp.mode) ? $past(core_req.offset) << 1 : $past(core_req.offset) << 2))
    else $error("bad offset scale");
  cop_kind_a: assert property (live_r && core_req.cop_valid && !core_req.exc_valid |=>
    core_rsp.rsvd_exc == (cr && $past(core_rsp.mode)) && core_rsp.cu_exc == !core_rsp.rsvd_exc)
    else $error("bad coprocessor fault");
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
endmodule
bind isamsw_ctrl isamsw_ctrl_monitor #(.COP_RSVD(COP_RSVD)) isamsw_ctrl_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .strap_cap(strap_cap), .core_req(core_req), .core_rsp(core_rsp));
`default_nettype wire

// [isamsw_core_model.sv]
/*
  far-side model: the core pipeline issuing one-cycle requests.
  assumes the bench hands a command with a go strobe on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module isamsw_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire isamsw_pkg::isamsw_req_t cmd,
  output isamsw_pkg::isamsw_req_t req
);
  import isamsw_pkg::*;
  // idle cycles invert stale fields so nothing matches by luck
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      req <= '0;
    else if (go)
      req <= cmd;
    else
    begin
      req <= ~req;
      req.jump_valid <= 1'b0;
      req.exc_valid <= 1'b0;
      req.eret_valid <= 1'b0;
      req.cop_valid <= 1'b0;
      req.offset <= cmd.offset;
    end
endmodule
`default_nettype wire

// [isamsw_ctrl_tb_top.sv]
/*
  self-checking bench: registers, random jumps, exceptions, returns, faults.
  assumes the core model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module isamsw_ctrl_tb_top;
  import isamsw_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0001715D;
  logic pready, pslverr, irq, er, m, esel = 1'b0, dsel = 1'b1;
  logic [1:0] cap = 2'h2;
  isamsw_req_t cmd = '0, req, c;
  isamsw_rsp_t rsp;
  int error_cnt = 0, check_count = 0, cyc = 0;
  isamsw_ctrl isamsw_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_cap(cap),
    .strap_exc_sel(esel), .strap_dbg_sel(dsel), .core_req(req), .core_rsp(rsp), .irq(irq));
  isamsw_core_model isamsw_core_model_inst (.pclk(pclk), .presetn(presetn), .go(go),
    .cmd(cmd), .req(req));
  initial forever #5 pclk = ~pclk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [OFS_W-1:0] scale(input logic [OFS_W-1:0] o, input logic md);
    return md ? o << 1 : o << 2;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the access until ready is seen; only the hang guard ends a lost answer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // the model drives at the second edge, the block answers after the third
  task automatic send(input isamsw_req_t q);
    m = rsp.mode;
    @(posedge pclk);
    cmd <= q;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    #1;
  endtask
  task automatic jump(input logic [63:0] s);
    c = '0;
    c.jump_valid = 1'b1;
    c.jump_link = 1'b1;
    c.jump_src = s;
    c.link_pc = {rnd(), rnd()};
    c.offset = rnd();
    send(c);
    chk(rsp.target_pc, {s[63:1], 1'b0});
    chk(rsp.link_value, {c.link_pc[63:1], m});
    chk(rsp.offset_scaled, scale(c.offset, m));
  endtask
  task automatic exc(input isamsw_kind_t k, input logic b, input logic x, input logic e);
    c = '0;
    c.exc_valid = 1'b1;
    c.exc_kind = k;
    c.exc_base_rel = b;
    c.exc_ctx = x;
    c.exc_pc = {rnd(), rnd()};
    send(c);
    chk(rsp.save_value, {c.exc_pc[63:1], m});
    chk(rsp.mode, e);
  endtask
  task automatic do_reset(input logic [1:0] k);
    @(posedge pclk);
    presetn <= 1'b0;
    cap <= k;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    do_reset(CAP_DUAL_WORD);
    chk(rsp.mode, MODE_WORD);
    // both selects must first show their straps, then the exception select its written value
    apb(1'b0, OFS_DBG_CTL, 32'h0);
    chk(rd[DBG_SEL_BIT], 1'b1);
    apb(1'b0, OFS_THIRD_CFG, 32'h0);
    chk(rd[EXC_SEL_BIT], 1'b0);
    apb(1'b1, OFS_THIRD_CFG, 32'h00010000);
    apb(1'b0, OFS_THIRD_CFG, 32'h0);
    chk(rd[15:14], CAP_DUAL_WORD);
    chk(rd[16], 1'b1);
    apb(1'b0, OFS_FIRST_CFG, 32'h0);
    chk(rd[LEGACY_CAP_BIT], 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd}, 33'h100000000);
    apb(1'b1, OFS_IRQ_MSK, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      jump({rnd(), rnd()});
      chk(rsp.mode, c.jump_src[0]);
    end
    // a jump that surely flips the mode, so the switch event is set
    jump(({rnd(), rnd()} & 64'hFFFFFFFFFFFFFFFE) | {63'h0, ~rsp.mode});
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, OFS_IRQ_MSK, 32'h0000000F);
    apb(1'b0, OFS_IRQ_STS, 32'h0);
    chk({irq, rd[EV_SWITCH]}, 2'h3);
    apb(1'b1, OFS_IRQ_STS, 32'h0000000F);
    apb(1'b0, OFS_IRQ_STS, 32'h0);
    chk({irq, rd[3:0]}, 5'h00);
    for (int d = 0; d < 2; d++)
    begin
      apb(1'b1, OFS_DBG_CTL, d);
      exc(EK_DEBUG, 1'b0, 1'b0, d[0]);
      exc(EK_GENERAL, 1'b1, 1'b0, 1'b1);
      exc(EK_ERROR, 1'b0, 1'b0, 1'b0);
    end
    apb(1'b1, OFS_CTX_SEL, 32'h1);
    apb(1'b1, OFS_THIRD_CFG, 32'h0);
    exc(EK_GENERAL, 1'b1, 1'b1, 1'b0);
    exc(EK_GENERAL, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      c = '0;
      c.eret_valid = 1'b1;
      c.eret_addr = {rnd(), rnd()};
      send(c);
      chk({rsp.target_pc, rsp.mode}, {c.eret_addr[63:1], 1'b0, c.eret_addr[0]});
      c = '0;
      c.cop_valid = 1'b1;
      send(c);
      chk({rsp.rsvd_exc, rsp.cu_exc}, {m, ~m});
    end
    do_reset(CAP_COMPACT_ONLY);
    jump(64'h0000000000001000);
    chk({rsp.addr_exc, rsp.link_value[0], rsp.mode}, 3'h7);
    complete_run();
  end
endmodule
`default_nettype wire
